/* File: anrcl_pkg.sv */
package anrcl_pkg;

    // ------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------
    localparam logic [7:0] NODE_IDENTIFIER_ADDR              = 8'h05;
    localparam logic [7:0] RESET_AND_PIN_MODE_CONTROL_ADDR   = 8'h50;
    localparam logic [7:0] OSCILLATOR_FREQUENCY_SETTING_ADDR = 8'h51;
    localparam logic [7:0] LINK_CONTROL_AND_STATUS_ADDR      = 8'h80;
    localparam logic [7:0] NODE_CONFIGURATION_ADDR           = 8'h04;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int NODE_ID_MSB       = 15;
    localparam int SYS_RESET_BIT     = 0;
    localparam int TILE_RESET_BIT    = 1;
    localparam int MODE_PINS_LSB     = 16;
    localparam int MODE_PINS_MSB     = 17;
    localparam int MODE_TRISTATE_BIT = 24;
    localparam int FREQ_MSB          = 6;
    localparam int TOKEN_GAP_MSB     = 10;
    localparam int TRANS_GAP_LSB     = 11;
    localparam int TRANS_GAP_MSB     = 21;
    localparam int RX_RESET_BIT      = 23;
    localparam int LINK_INIT_BIT     = 24;
    localparam int TX_CREDIT_BIT     = 25;
    localparam int RX_CREDIT_BIT     = 26;
    localparam int LINK_ERROR_BIT    = 27;
    localparam int LOCK_BIT          = 31;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] NODE_ID_RESET   = 16'h0000;
    localparam logic [6:0]  FREQ_RESET      = 7'h19;
    localparam logic [6:0]  FREQ_MIN        = 7'h05;
    localparam logic [6:0]  FREQ_MAX        = 7'h64;
    localparam logic [10:0] GAP_RESET       = 11'h001;
    localparam logic [1:0]  MODE_PINS_RESET = 2'h0;
    localparam logic        TRISTATE_RESET  = 1'b0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_RESET_OSC_CYCLES = 524288;
    localparam int CLK_MHZ              = 200;
    localparam int TILE_RESET_CYCLES    = 16;
    localparam int KHZ_PER_MHZ          = 1000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ANRCL_ACK  = 2'b01,
        ANRCL_NACK = 2'b10,
        ANRCL_NONE = 2'b00
    } anrcl_resp_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        want_resp;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } anrcl_req_type;

    typedef struct packed {
        logic           valid;
        anrcl_resp_type kind;
        logic [31:0]    rdata;
    } anrcl_ans_type;

    typedef struct packed {
        logic overflow;
        logic bad_token;
        logic rx_credit;
        logic tx_credit;
        logic credit_request_token_done;
    } anrcl_link_stat_type;

endpackage : anrcl_pkg

/* File: anrcl_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// Divides the 200 MHz clock into oscillator-cycle and 1 kHz ticks
module anrcl_tick_gen #(
    parameter int CLK_MHZ = anrcl_pkg::CLK_MHZ
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [6:0] freq_mhz,
    output logic            osc_tick,
    output logic            khz_tick,
    output logic            sec_tick
);
    logic [15:0] acc;
    logic [9:0]  sec_cnt;
    wire  [15:0] next_acc  = acc + {9'h000, freq_mhz};
    wire         wrap      = next_acc >= 16'(CLK_MHZ);

    // Fractional accumulator: freq_mhz ticks every CLK_MHZ clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc      <= 16'h0000;
            osc_tick <= 1'b0;
        end else begin
            acc      <= wrap ? next_acc - 16'(CLK_MHZ) : next_acc;
            osc_tick <= wrap;
        end
    end

    // Millisecond and second ticks
    wire [16:0] khz_lim = 17'(freq_mhz) * 17'(anrcl_pkg::KHZ_PER_MHZ);
    logic [16:0] osc_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_cnt  <= 17'h00000;
            khz_tick <= 1'b0;
            sec_cnt  <= 10'h000;
            sec_tick <= 1'b0;
        end else begin
            khz_tick <= 1'b0;
            sec_tick <= 1'b0;
            if (osc_tick) begin
                if (osc_cnt + 17'h00001 >= khz_lim) begin
                    osc_cnt  <= 17'h00000;
                    khz_tick <= 1'b1;
                    if (sec_cnt == 10'(anrcl_pkg::KHZ_PER_MHZ - 1)) begin
                        sec_cnt  <= 10'h000;
                        sec_tick <= 1'b1;
                    end else begin
                        sec_cnt <= sec_cnt + 10'h001;
                    end
                end else begin
                    osc_cnt <= osc_cnt + 17'h00001;
                end
            end
        end
    end
endmodule : anrcl_tick_gen
`default_nettype wire

/* File: anrcl_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 16-bit node identifier, read-write, resets zero
// - Separate system and tile reset scopes
// - Pin, brown-out, watchdog raise system reset
// - Sleep and clock change raise tile reset
// - System reset lasts 524288 oscillator cycles
// - Tile reset bit starts tile reset, self-clears
// - System reset bit starts system reset, self-clears
// - Reset-bit writes get no response packet
// - Mode pin field plus tristate bit
// - 7-bit frequency field, resets to 25
// - Out-of-range frequency write ignored and NACKed
// - Frequency drives reset delay, watchdog, sleep clock
// - Link error sticky, cleared by register read
// - Report issued and held link credit
// - Link init clears credit, sends credit request
// - Receiver reset restarts token symbol framing
// - Transition spacing field, resets to one
// - Token spacing field, resets to one
// - Lock bit freezes node config and link registers
module anrcl_regs #(
    parameter int SYS_RESET_OSC_CYCLES = anrcl_pkg::SYS_RESET_OSC_CYCLES,
    parameter int TILE_RESET_CYCLES    = anrcl_pkg::TILE_RESET_CYCLES
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire anrcl_pkg::anrcl_req_type       req,
    output anrcl_pkg::anrcl_ans_type            ans,
    input  wire logic                           ext_reset_n,
    input  wire logic                           brown_out,
    input  wire logic                           watchdog_expired,
    input  wire logic                           sleep_sequence,
    input  wire logic                           clock_source_change,
    input  wire anrcl_pkg::anrcl_link_stat_type link_stat,
    output logic                                system_reset,
    output logic                                tile_reset,
    output logic [1:0]                          mode_pins_out,
    output logic                                mode_pins_oe_n,
    output logic [6:0]                          freq_mhz,
    output logic                                link_init_pulse,
    output logic                                rx_reset_pulse,
    output logic [10:0]                         transition_gap,
    output logic [10:0]                         token_gap,
    output logic                                osc_tick,
    output logic                                khz_tick,
    output logic                                sleep_sec_tick
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] node_identifier;
    logic [1:0]  mode_pins;
    logic        mode_tristate;
    logic        lock;
    logic        header_mode;
    logic        link_error;
    logic        tx_credit;
    logic [19:0] sys_cnt;
    logic [7:0]  tile_cnt;

    typedef enum logic [1:0] {
        ANRCL_RUN      = 2'b00,
        ANRCL_SYS_HOLD = 2'b01,
        ANRCL_TILE     = 2'b10
    } anrcl_rst_state_type;
    anrcl_rst_state_type state;
    anrcl_rst_state_type next_state;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire        wr        = req.valid && req.write;
    wire        rd        = req.valid && !req.write;
    wire [31:0] wd        = req.wdata;
    wire        sel_id    = req.addr == anrcl_pkg::NODE_IDENTIFIER_ADDR;
    wire        sel_rst   = req.addr == anrcl_pkg::RESET_AND_PIN_MODE_CONTROL_ADDR;
    wire        sel_freq  = req.addr == anrcl_pkg::OSCILLATOR_FREQUENCY_SETTING_ADDR;
    wire        sel_link  = req.addr == anrcl_pkg::LINK_CONTROL_AND_STATUS_ADDR;
    wire        sel_cfg   = req.addr == anrcl_pkg::NODE_CONFIGURATION_ADDR;
    wire        mapped    = sel_id | sel_rst | sel_freq | sel_link | sel_cfg;
    wire [6:0]  wr_freq   = wd[anrcl_pkg::FREQ_MSB:0];
    wire        freq_ok   = wr_freq >= anrcl_pkg::FREQ_MIN && wr_freq <= anrcl_pkg::FREQ_MAX;
    wire        sw_sys    = wr && sel_rst && wd[anrcl_pkg::SYS_RESET_BIT];
    wire        sw_tile   = wr && sel_rst && wd[anrcl_pkg::TILE_RESET_BIT];
    wire        silent    = sw_sys || sw_tile;
    wire        link_wr   = wr && sel_link && !lock;
    wire        cfg_wr    = wr && sel_cfg && !lock;
    wire        bad_wr    = (wr && sel_freq && !freq_ok) || !mapped
                            || (wr && (sel_link || sel_cfg) && lock);
    wire        hw_sys    = !ext_reset_n || brown_out || watchdog_expired;
    wire        hw_tile   = sleep_sequence || clock_source_change;
    wire        link_err_set = link_stat.overflow || link_stat.bad_token;
    wire        link_rd   = rd && sel_link;

    // ------------------------------------------------------------
    // Read data (reserved bits zero)
    // ------------------------------------------------------------
    wire [31:0] rd_id   = {16'h0000, node_identifier};
    wire [31:0] rd_rst  = {7'h00, mode_tristate, 6'h00, mode_pins, 16'h0000};
    wire [31:0] rd_freq = {25'h0000000, freq_mhz};
    wire [31:0] rd_link = {4'h0, link_error, link_stat.rx_credit, tx_credit,
                           2'b00, 1'b0, transition_gap, token_gap};
    wire [31:0] rd_cfg  = {lock, 30'h00000000, header_mode};
    wire [31:0] rd_mux  = sel_id ? rd_id : sel_rst ? rd_rst : sel_freq ? rd_freq
                        : sel_link ? rd_link : sel_cfg ? rd_cfg : 32'h00000000;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            node_identifier <= anrcl_pkg::NODE_ID_RESET;
            mode_pins       <= anrcl_pkg::MODE_PINS_RESET;
            mode_tristate   <= anrcl_pkg::TRISTATE_RESET;
            freq_mhz        <= anrcl_pkg::FREQ_RESET;
            transition_gap  <= anrcl_pkg::GAP_RESET;
            token_gap       <= anrcl_pkg::GAP_RESET;
            lock            <= 1'b0;
            header_mode     <= 1'b0;
        end else if (state == ANRCL_SYS_HOLD) begin
            node_identifier <= anrcl_pkg::NODE_ID_RESET;
            mode_pins       <= anrcl_pkg::MODE_PINS_RESET;
            mode_tristate   <= anrcl_pkg::TRISTATE_RESET;
            transition_gap  <= anrcl_pkg::GAP_RESET;
            token_gap       <= anrcl_pkg::GAP_RESET;
            lock            <= 1'b0;
            header_mode     <= 1'b0;
        end else begin
            if (wr && sel_id)
                node_identifier <= wd[anrcl_pkg::NODE_ID_MSB:0];
            if (wr && sel_rst) begin
                mode_pins     <= wd[anrcl_pkg::MODE_PINS_MSB:anrcl_pkg::MODE_PINS_LSB];
                mode_tristate <= wd[anrcl_pkg::MODE_TRISTATE_BIT];
            end
            if (wr && sel_freq && freq_ok)
                freq_mhz <= wr_freq;
            if (link_wr) begin
                transition_gap <= wd[anrcl_pkg::TRANS_GAP_MSB:anrcl_pkg::TRANS_GAP_LSB];
                token_gap      <= wd[anrcl_pkg::TOKEN_GAP_MSB:0];
            end
            if (cfg_wr) begin
                lock        <= wd[anrcl_pkg::LOCK_BIT];
                header_mode <= wd[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Link status and strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_error      <= 1'b0;
            tx_credit       <= 1'b0;
            link_init_pulse <= 1'b0;
            rx_reset_pulse  <= 1'b0;
        end else begin
            link_error      <= link_err_set || (link_error && !link_rd);
            link_init_pulse <= link_wr && wd[anrcl_pkg::LINK_INIT_BIT];
            rx_reset_pulse  <= link_wr && wd[anrcl_pkg::RX_RESET_BIT];
            if (link_wr && wd[anrcl_pkg::LINK_INIT_BIT])
                tx_credit <= 1'b0;
            else
                tx_credit <= link_stat.tx_credit;
        end
    end

    // ------------------------------------------------------------
    // Answers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ans <= '0;
        end else begin
            ans.valid <= req.valid && req.want_resp && !silent;
            ans.kind  <= bad_wr ? anrcl_pkg::ANRCL_NACK : anrcl_pkg::ANRCL_ACK;
            ans.rdata <= rd ? rd_mux : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    wire sys_done  = sys_cnt == 20'(SYS_RESET_OSC_CYCLES - 1);
    wire tile_done = tile_cnt == 8'(TILE_RESET_CYCLES - 1);

    always_comb begin
        next_state = state;
        case (state)
            ANRCL_RUN: begin
                if (hw_sys || sw_sys)
                    next_state = ANRCL_SYS_HOLD;
                else if (hw_tile || sw_tile)
                    next_state = ANRCL_TILE;
            end
            ANRCL_SYS_HOLD: begin
                if (sys_done && osc_tick && !hw_sys)
                    next_state = ANRCL_RUN;
            end
            ANRCL_TILE: begin
                if (hw_sys || sw_sys)
                    next_state = ANRCL_SYS_HOLD;
                else if (tile_done && osc_tick)
                    next_state = ANRCL_RUN;
            end
            default: next_state = ANRCL_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state        <= ANRCL_SYS_HOLD;
            sys_cnt      <= 20'h00000;
            tile_cnt     <= 8'h00;
            system_reset <= 1'b1;
            tile_reset   <= 1'b1;
        end else begin
            state <= next_state;
            if (state != ANRCL_SYS_HOLD || hw_sys)
                sys_cnt <= 20'h00000;
            else if (osc_tick)
                sys_cnt <= sys_cnt + 20'h00001;
            if (state != ANRCL_TILE)
                tile_cnt <= 8'h00;
            else if (osc_tick)
                tile_cnt <= tile_cnt + 8'h01;
            system_reset <= next_state == ANRCL_SYS_HOLD;
            tile_reset   <= next_state != ANRCL_RUN;
        end
    end

    // ------------------------------------------------------------
    // Frequency-derived timing
    // ------------------------------------------------------------

    anrcl_tick_gen #(
        .CLK_MHZ (anrcl_pkg::CLK_MHZ)
    ) u_tick (
        .clk      (clk),
        .rst      (rst),
        .freq_mhz (freq_mhz),
        .osc_tick (osc_tick),
        .khz_tick (khz_tick),
        .sec_tick (sleep_sec_tick)
    );

    assign mode_pins_out  = mode_pins;
    assign mode_pins_oe_n = mode_tristate;
endmodule : anrcl_regs
`default_nettype wire

/* File: anrcl_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module anrcl_regs_assertions #(
    parameter int SYS_RESET_OSC_CYCLES = 524288,
    parameter int TILE_RESET_CYCLES    = 16
) (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire anrcl_pkg::anrcl_req_type req,
    input wire anrcl_pkg::anrcl_ans_type ans,
    input wire logic                     ext_reset_n,
    input wire logic                     brown_out,
    input wire logic                     watchdog_expired,
    input wire logic                     sleep_sequence,
    input wire logic                     clock_source_change,
    input wire logic                     system_reset,
    input wire logic                     tile_reset,
    input wire logic [1:0]               mode_pins_out,
    input wire logic                     mode_pins_oe_n,
    input wire logic [6:0]               freq_mhz,
    input wire logic                     link_init_pulse,
    input wire logic                     rx_reset_pulse,
    input wire logic                     osc_tick
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    wire wr      = req.valid && req.write;
    wire rst_wr  = wr && req.addr == 8'h50 && req.wdata[1:0] != 2'h0;
    wire mode_wr = wr && req.addr == 8'h50 && req.wdata[1:0] == 2'h0 && !system_reset;
    wire f_wr    = wr && req.addr == 8'h51;
    wire f_bad   = req.wdata[6:0] < 7'd5 || req.wdata[6:0] > 7'd100;
    wire init_wr = wr && req.addr == 8'h80 && req.wdata[24];
    wire rxr_wr  = wr && req.addr == 8'h80 && req.wdata[23];
    wire cause   = !ext_reset_n || brown_out || watchdog_expired || (rst_wr && req.wdata[0]);
    logic [31:0] n_osc;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            n_osc <= 32'h0;
        else if (cause || !system_reset)
            n_osc <= 32'h0;
        else if (osc_tick)
            n_osc <= n_osc + 32'h1;
    end
    a_no_ans: assert property (rst_wr |=> !ans.valid) else $error("answer after reset write");
    a_bad_freq: assert property (f_wr && f_bad && req.want_resp |=> ans.valid
        && ans.kind == anrcl_pkg::ANRCL_NACK && freq_mhz == $past(freq_mhz))
        else $error("bad frequency not refused");
    a_freq: assert property (f_wr && !f_bad |=> freq_mhz == $past(req.wdata[6:0]))
        else $error("frequency not loaded");
    a_sys_bit: assert property (rst_wr && req.wdata[0] |=> system_reset && tile_reset)
        else $error("system reset bit ignored");
    a_tile_bit: assert property (rst_wr && req.wdata[1] |=> tile_reset)
        else $error("tile reset bit ignored");
    a_sys_cause: assert property (cause |-> ##[1:2] system_reset)
        else $error("system reset cause ignored");
    a_tile_cause: assert property (sleep_sequence || clock_source_change |-> ##[1:2] tile_reset)
        else $error("tile reset cause ignored");
    a_scope: assert property (system_reset |-> tile_reset) else $error("tile not in reset");
    a_sys_len: assert property ($fell(system_reset) |-> n_osc + 32'h1 >= SYS_RESET_OSC_CYCLES
        && n_osc <= SYS_RESET_OSC_CYCLES + 1) else $error("system reset length wrong");
    a_mode: assert property (mode_wr |=> mode_pins_out == $past(req.wdata[17:16])
        && mode_pins_oe_n == $past(req.wdata[24])) else $error("mode pins wrong");
    a_init: assert property (link_init_pulse |-> $past(init_wr) ##1 !link_init_pulse)
        else $error("init pulse wrong");
    a_rxr: assert property (rx_reset_pulse |-> $past(rxr_wr) ##1 !rx_reset_pulse)
        else $error("receiver reset pulse wrong");
endmodule : anrcl_regs_assertions
bind anrcl_regs anrcl_regs_assertions #(.SYS_RESET_OSC_CYCLES(SYS_RESET_OSC_CYCLES),
    .TILE_RESET_CYCLES(TILE_RESET_CYCLES)) i_anrcl_regs_assertions (.clk, .rst, .req, .ans,
    .ext_reset_n, .brown_out, .watchdog_expired, .sleep_sequence, .clock_source_change,
    .system_reset, .tile_reset, .mode_pins_out, .mode_pins_oe_n, .freq_mhz, .link_init_pulse,
    .rx_reset_pulse, .osc_tick);
`default_nettype wire

/* File: anrcl_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module anrcl_far_end #(
    parameter int GRANT_DELAY = 8
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          link_init_pulse,
    input  wire logic                          inject_overflow,
    input  wire logic                          inject_bad,
    output var anrcl_pkg::anrcl_link_stat_type link_stat
);
    logic credit;
    int   wait_cnt;
    assign link_stat = {inject_overflow, inject_bad, credit, credit, 1'b0};
    // Credits come back some cycles after a credit request token
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            credit   <= 1'b0;
            wait_cnt <= 0;
        end else if (link_init_pulse) begin
            credit   <= 1'b0;
            wait_cnt <= GRANT_DELAY;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
            credit   <= (wait_cnt == 1);
        end
    end
endmodule : anrcl_far_end
`default_nettype wire

/* File: anrcl_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module anrcl_regs_tb;
    localparam int SYS_N = 64;
    logic                           clk = 1'b0;
    logic                           rst = 1'b1;
    anrcl_pkg::anrcl_req_type       req = '0;
    anrcl_pkg::anrcl_ans_type       ans;
    anrcl_pkg::anrcl_ans_type       got;
    anrcl_pkg::anrcl_link_stat_type link_stat;
    logic [2:0]                     pins = 3'b100;
    logic [1:0]                     tile_causes = 2'b00;
    logic                           inj_ovf = 1'b0;
    logic                           inj_bad = 1'b0;
    logic                           system_reset, tile_reset, mode_pins_oe_n, osc_tick;
    logic                           link_init_pulse, rx_reset_pulse, khz_tick, sleep_sec_tick;
    logic [1:0]                     mode_pins_out;
    logic [6:0]                     freq_mhz;
    logic [6:0]                     fexp = 7'h19;
    logic [6:0]                     fv [7] = '{7'h64, 7'h04, 7'h65, 7'h00, 7'h05, 7'h7F, 7'h32};
    logic [10:0]                    transition_gap, token_gap;
    logic [10:0]                    tg = 11'h7FF;
    logic [10:0]                    kg = 11'h2AA;
    logic                           p_init, p_rx, good;
    int                             n_errors = 0;
    int                             num_checks = 0;
    int                             n;

    always #2.5 clk = ~clk;

    anrcl_regs #(.SYS_RESET_OSC_CYCLES(SYS_N)) i_anrcl_regs (.clk, .rst, .req, .ans,
        .ext_reset_n(pins[2]), .brown_out(pins[1]), .watchdog_expired(pins[0]),
        .sleep_sequence(tile_causes[1]), .clock_source_change(tile_causes[0]), .link_stat,
        .system_reset, .tile_reset, .mode_pins_out, .mode_pins_oe_n, .freq_mhz, .link_init_pulse,
        .rx_reset_pulse, .transition_gap, .token_gap, .osc_tick, .khz_tick, .sleep_sec_tick);
    anrcl_far_end i_anrcl_far_end (.clk, .rst, .link_init_pulse, .inject_overflow(inj_ovf),
        .inject_bad(inj_bad), .link_stat);

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string what);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask : chk_val

    task automatic chk_ans(input logic v, input logic [1:0] k, input logic [31:0] d);
        chk_val({31'h0, got.valid}, {31'h0, v}, "answer valid");
        if (v) begin
            chk_val({30'h0, got.kind}, {30'h0, k}, "answer kind");
            chk_val(got.rdata, d, "read data");
        end
    endtask : chk_ans

    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        req = '{valid: 1'b1, write: w, want_resp: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        got = ans;
        p_init = link_init_pulse;
        p_rx = rx_reset_pulse;
        req.valid = 1'b0;
    endtask : access

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        access(1'b0, a, 32'h0);
        chk_ans(1'b1, anrcl_pkg::ANRCL_ACK, e);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] k);
        access(1'b1, a, d);
        chk_ans(1'b1, k, 32'h0);
    endtask : wr

    task automatic wait_quiet();
        n = 0;
        while ((system_reset !== 1'b0 || tile_reset !== 1'b0) && n < 4000) begin
            @(negedge clk);
            n++;
        end
        chk_val(n < 4000, 1, "reset release");
    endtask : wait_quiet

    initial begin
        #300000;
        n_errors++;
        conclude();
    end

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chk_val(system_reset, 1, "system reset after power up");
        wait_quiet();
        rd(8'h05, 32'h0);
        rd(8'h51, 32'h19);
        rd(8'h50, 32'h0);
        rd(8'h80, 32'h0801);
        access(1'b0, 8'h33, 32'h0);
        chk_ans(1'b1, anrcl_pkg::ANRCL_NACK, 32'h0);
        wr(8'h05, 32'hFFFFFFFF, anrcl_pkg::ANRCL_ACK);
        rd(8'h05, 32'h0000FFFF);
        foreach (fv[i]) begin
            good = fv[i] >= 7'h05 && fv[i] <= 7'h64;
            wr(8'h51, {25'h0, fv[i]}, good ? anrcl_pkg::ANRCL_ACK : anrcl_pkg::ANRCL_NACK);
            if (good)
                fexp = fv[i];
            chk_val({25'h0, freq_mhz}, {25'h0, fexp}, "frequency");
        end
        n = 0;
        repeat (2000) @(negedge clk) if (osc_tick === 1'b1) n++;
        chk_val(n, 500, "oscillator ticks");
        wr(8'h51, 32'h19, anrcl_pkg::ANRCL_ACK);
        wr(8'h50, 32'hFFFFFFFC, anrcl_pkg::ANRCL_ACK);
        chk_val({mode_pins_oe_n, mode_pins_out}, 3'b111, "mode pins");
        rd(8'h50, 32'h01030000);
        wr(8'h50, 32'h00010000, anrcl_pkg::ANRCL_ACK);
        chk_val({mode_pins_oe_n, mode_pins_out}, 3'b001, "mode pins");
        wr(8'h80, {7'h7F, 3'h1, tg, kg}, anrcl_pkg::ANRCL_ACK);
        chk_val({transition_gap, token_gap}, {tg, kg}, "gaps");
        rd(8'h80, {10'h0, tg, kg});
        repeat (2) begin
            wr(8'h80, {7'h0, 3'h4, tg, kg}, anrcl_pkg::ANRCL_ACK);
            chk_val(p_init, 1, "init pulse");
            repeat (2) @(negedge clk);
            rd(8'h80, {10'h0, tg, kg});
            repeat (12) @(negedge clk);
            rd(8'h80, {5'h0, 5'h18, tg, kg});
        end
        wr(8'h80, {7'h0, 3'h2, tg, kg}, anrcl_pkg::ANRCL_ACK);
        chk_val({p_rx, p_init}, 2'b10, "receiver reset pulse");
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            {inj_ovf, inj_bad} = (i == 0) ? 2'b10 : 2'b01;
            @(negedge clk);
            {inj_ovf, inj_bad} = 2'b00;
            rd(8'h80, {4'h0, 6'h38, tg, kg});
            rd(8'h80, {4'h0, 6'h18, tg, kg});
        end
        wr(8'h04, 32'h80000000, anrcl_pkg::ANRCL_ACK);
        wr(8'h80, 32'h00001803, anrcl_pkg::ANRCL_NACK);
        chk_val({transition_gap, token_gap}, {tg, kg}, "locked gaps");
        access(1'b1, 8'h50, 32'h2);
        chk_ans(1'b0, 2'h0, 32'h0);
        chk_val({system_reset, tile_reset}, 2'b01, "tile reset");
        wait_quiet();
        access(1'b1, 8'h50, 32'h1);
        chk_ans(1'b0, 2'h0, 32'h0);
        chk_val({system_reset, tile_reset}, 2'b11, "system reset");
        wait_quiet();
        rd(8'h05, 32'h0);
        rd(8'h50, 32'h0);
        wr(8'h80, 32'h00000801, anrcl_pkg::ANRCL_ACK);
        foreach (fv[i]) if (i < 3) begin
            pins = (i == 0) ? 3'b000 : (i == 1) ? 3'b110 : 3'b101;
            repeat (2) @(negedge clk);
            pins = 3'b100;
            chk_val(system_reset, 1, "system reset cause");
            wait_quiet();
        end
        for (int i = 1; i < 3; i++) begin
            tile_causes = i[1:0];
            @(negedge clk);
            tile_causes = 2'b00;
            @(negedge clk);
            chk_val({system_reset, tile_reset}, 2'b01, "tile reset cause");
            wait_quiet();
        end
        wr(8'h51, 32'h32, anrcl_pkg::ANRCL_ACK);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        wait_quiet();
        rd(8'h51, 32'h19);
        conclude();
    end
endmodule : anrcl_regs_tb
`default_nettype wire
